// file: rtl/clb_pkg.sv
// package for the logic cluster model: sizes, modes, reset values
// assumes one clock domain; included first in compile order
package clb_pkg;

  localparam int LUT_DEPTH     = 16;   // entries per function generator
  localparam int LUT_ADDR_W    = 4;    // address lines per generator
  localparam int SLICES        = 4;    // slices per cluster
  localparam int LUTS          = 8;    // generators per cluster
  localparam int BUS_LINES     = 4;    // horizontal bus lines per cluster
  localparam int BUS_DRIVERS   = 2;    // bus drivers per cluster
  localparam int CARRY_CHAINS  = 2;    // independent carry chains
  localparam int CARRY_BITS    = 4;    // bits per chain (two per slice)
  localparam int CHAIN_LEN     = 128;  // addressable shift bits per cluster
  localparam int CHAIN_ADDR_W  = 7;
  localparam logic RESET_FLAG  = 1'b0;

  // generator operating modes, one-hot
  typedef enum logic [3:0] {
    CLB_MODE_SPRAM = 4'h1,
    CLB_MODE_DPRAM = 4'h2,
    CLB_MODE_ROM   = 4'h4,
    CLB_MODE_SHIFT = 4'h8
  } clb_mode_e;

  typedef logic [LUT_DEPTH-1:0] clb_word_t;

endpackage : clb_pkg

// file: rtl/clb_lut_cell.sv
// one 16x1 function generator: RAM, ROM or addressable shift register
// assumes write/shift requests come from logic on clk, no pin crossing
`timescale 1ns/1ps
module clb_lut_cell
  import clb_pkg::*;
#(
  parameter clb_word_t INIT = '0
) (
  input  wire logic                  clk,
  input  wire clb_mode_e             mode,
  input  wire logic [LUT_ADDR_W-1:0] readAddr,
  input  wire logic [LUT_ADDR_W-1:0] writeAddr,
  input  wire logic                  writeEn,
  input  wire logic                  writeData,
  input  wire logic                  shiftEn,
  input  wire logic                  shiftIn,
  output logic                       readData,
  output logic                       cascadeOut
);

  // storage has no reset on purpose: contents only change by write or shift
  typedef struct packed {
    clb_word_t mem;
  } clb_cell_s;

  // configuration load as a declaration value, so the flop keeps one writer
  clb_cell_s cell_reg = '{mem: INIT};
  clb_cell_s cell_next;

  //////////////////////////////////////////////////////////////////////////
  // next contents
  always_comb begin
    cell_next = cell_reg;
    // (R20) stage advance
    if (mode == CLB_MODE_SHIFT && shiftEn) begin
      cell_next.mem = {cell_reg.mem[LUT_DEPTH-2:0], shiftIn};
    end else if ((mode == CLB_MODE_SPRAM || mode == CLB_MODE_DPRAM) && writeEn) begin
      cell_next.mem[writeAddr] = writeData;
    end
  end

  // (R09) no set or reset
  always_ff @(posedge clk) begin
    cell_reg <= cell_next;
  end

  // (R08) combinational tap read
  assign readData   = cell_reg.mem[readAddr];
  // (R11) last stage cascade
  assign cascadeOut = cell_reg.mem[LUT_DEPTH-1];

endmodule // clb_lut_cell

// file: rtl/clb_cluster.sv
// one logic cluster: eight generators, wide muxes, carry, sum chain, bus
// assumes all user inputs are on clk; memory outputs are combinational
`timescale 1ns/1ps

// Operation
// (R01) single-port memory: one address, clocked write, combinational read
// (R02) dual-port memory adds a combinational read-only second port
// (R03) each generator has separate four-line read and write addresses
// (R04) single-port mode ties read and write address together
// (R05) dual-port second generator reads port-two address, writes port-one address
// (R06) generators act as 16x1 ROM, cascading to 256 entries over two clusters
// (R07) generator shifts 16 bits on clock with optional enable
// (R08) shift tap selected by four-bit address, read combinationally
// (R09) shift stages have no set or reset
// (R10) user logic keeps tap constant when registering it in a flip-flop
// (R11) cascade links last stage into next, giving 128-bit addressable chain
// (R12) muxes: 2:1 per generator up to 32:1 over two clusters
// (R13) per slice five-input and upper-level mux; cluster has 6,6,7,8 stages
// (R14) two upward carry chains, two bits per slice, for add/subtract
// (R15) per-slice XOR for full adder and AND for partial products
// (R16) sum chain OR combines previous OR and own top carry output
// (R17) two bus drivers with own input and enable, AND-OR built
// (R18) four bus lines, each driver alternately reaches two of them
// (R19) user drives memory write enable active high on slice clock
// (R20) enabled shift moves stages up, loads serial input at stage zero
// (R21) bus line is OR of input AND enable; one enable per line
module clb_cluster
  import clb_pkg::*;
#(
  parameter logic [LUTS*LUT_DEPTH-1:0] ROM_INIT = '0
) (
  input  wire logic                               clk,
  input  wire logic                               rst_b,
  input  wire clb_mode_e                          mode,
  input  wire logic [LUT_ADDR_W-1:0]              addr,
  input  wire logic [LUT_ADDR_W-1:0]              readOnlyAddr,
  input  wire logic [3:0]                         wideSel,
  input  wire logic [3:0]                         writeData,
  input  wire logic                               writeEn,
  input  wire logic                               shiftEn,
  input  wire logic                               shiftIn,
  input  wire logic [CHAIN_ADDR_W-1:0]            chainAddr,
  input  wire logic [CARRY_CHAINS*CARRY_BITS-1:0] addA,
  input  wire logic [CARRY_CHAINS*CARRY_BITS-1:0] addB,
  input  wire logic [CARRY_CHAINS-1:0]            carryIn,
  input  wire logic [CARRY_CHAINS-1:0]            subtract,
  input  wire logic [CARRY_CHAINS*CARRY_BITS-1:0] ppA,
  input  wire logic [CARRY_CHAINS*CARRY_BITS-1:0] ppB,
  input  wire logic [SLICES-1:0]                  sopIn,
  input  wire logic                               upperWideIn,
  input  wire logic [BUS_DRIVERS-1:0]             busDrvData,
  input  wire logic [BUS_DRIVERS-1:0]             busDrvEnable,
  input  wire logic [BUS_DRIVERS-1:0]             busDrvLineSel,
  input  wire logic [BUS_LINES-1:0]               busLineIn,
  output logic [LUTS-1:0]                         lutRead,
  output logic [3:0]                              dualPortRead,
  output logic                                    wideMuxOut,
  output logic                                    wideMuxEightOut,
  output logic                                    shiftChainOut,
  output logic                                    shiftCascadeOut,
  output logic [CARRY_CHAINS*CARRY_BITS-1:0]      sum,
  output logic [CARRY_CHAINS*CARRY_BITS-1:0]      productBits,
  output logic [CARRY_CHAINS-1:0]                 carryOut,
  output logic [SLICES-1:0]                       sopOut,
  output logic [BUS_LINES-1:0]                    busLineOut,
  output logic                                    shiftTapReg
);

  ////////////////////////////////////////////////////////////////////////////
  // generator address and data routing

  logic [LUT_ADDR_W-1:0] lutRdAddr [LUTS];
  logic [LUT_ADDR_W-1:0] lutWrAddr [LUTS];
  logic [LUTS-1:0]       lutWrData;
  logic [LUTS-1:0]       lutWrEn;
  logic [LUTS-1:0]       lutShiftIn;
  logic [LUTS-1:0]       lutCascade;

  // chain position of generator i reads its tap from the chain address low bits
  function automatic logic [LUT_ADDR_W-1:0] pick_read_addr(input int idx);
    logic [LUT_ADDR_W-1:0] a;
    a = addr;
    // (R05) odd generators are the read-only copy in dual-port mode
    if (mode == CLB_MODE_DPRAM && idx[0]) begin
      a = readOnlyAddr;
    end else if (mode == CLB_MODE_SHIFT) begin
      a = chainAddr[LUT_ADDR_W-1:0];
    end
    return a;
  endfunction

  always_comb begin
    for (int i = 0; i < LUTS; i++) begin
      // (R03) read and write addresses kept separate
      lutRdAddr[i]  = pick_read_addr(i);
      // (R04) shared address in single-port, port-one address for writes
      lutWrAddr[i]  = addr;
      // dual-port pairs hold same data bit, single-port generators i and i+4 share bit i%4
      lutWrData[i]  = (mode == CLB_MODE_DPRAM) ? writeData[i/2] : writeData[i%4];
      // (R19) active-high write enable, sampled on clk
      lutWrEn[i]    = writeEn;
    end
    // (R11) dedicated cascade from previous generator's last stage
    lutShiftIn = {lutCascade[LUTS-2:0], shiftIn};
  end

  ////////////////////////////////////////////////////////////////////////////
  // eight generators

  for (genvar g = 0; g < LUTS; g++) begin : g_lut
    // (R01) (R02) (R06) (R07) generator instance per position
    clb_lut_cell #(
      .INIT (ROM_INIT[g*LUT_DEPTH +: LUT_DEPTH])
    ) u_cell (
      .clk        (clk),
      .mode       (mode),
      .readAddr   (lutRdAddr[g]),
      .writeAddr  (lutWrAddr[g]),
      .writeEn    (lutWrEn[g]),
      .writeData  (lutWrData[g]),
      .shiftEn    (shiftEn),
      .shiftIn    (lutShiftIn[g]),
      .readData   (lutRead[g]),
      .cascadeOut (lutCascade[g])
    );
  end

  // dual-port: even = read/write port, odd = read-only port
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      // (R02) second read port
      dualPortRead[p] = lutRead[2*p+1];
    end
  end

  assign shiftCascadeOut = lutCascade[LUTS-1];

  ////////////////////////////////////////////////////////////////////////////
  // wide multiplexers

  logic [SLICES-1:0] wideMuxFiveIn;
  logic [1:0]        wideMuxSixIn;
  logic              wideMuxSevenIn;

  // (R12) (R13) five-input per slice, then 6,6,7 and 8 level stages
  always_comb begin
    for (int s = 0; s < SLICES; s++) begin
      wideMuxFiveIn[s] = wideSel[0] ? lutRead[2*s+1] : lutRead[2*s];
    end
    wideMuxSixIn[0] = wideSel[1] ? wideMuxFiveIn[1] : wideMuxFiveIn[0];
    wideMuxSixIn[1] = wideSel[1] ? wideMuxFiveIn[3] : wideMuxFiveIn[2];
    wideMuxSevenIn  = wideSel[2] ? wideMuxSixIn[1] : wideMuxSixIn[0];
    // eight-input stage takes a neighbouring cluster's seven-input result
    wideMuxEightOut = wideSel[3] ? upperWideIn : wideMuxSevenIn;
  end

  // shift chain: low address bits tap the generator, upper bits pick it
  always_comb begin
    // (R11) 128-bit addressable chain, own 8:1 pick by chainAddr upper bits, replaces wideMuxOut in shift mode
    shiftChainOut = lutRead[chainAddr[CHAIN_ADDR_W-1:LUT_ADDR_W]];
    wideMuxOut    = (mode == CLB_MODE_SHIFT) ? shiftChainOut : wideMuxSevenIn;
  end

  ////////////////////////////////////////////////////////////////////////////
  // carry chains and arithmetic gates

  logic [CARRY_CHAINS*CARRY_BITS-1:0] topCarry;

  // ripple temporaries live at the top so every path starts from a value
  always_comb begin
    logic cy;
    logic prop;
    logic bIn;
    cy          = 1'b0;
    prop        = 1'b0;
    bIn         = 1'b0;
    sum         = '0;
    productBits = '0;
    carryOut    = '0;
    topCarry    = '0;
    for (int c = 0; c < CARRY_CHAINS; c++) begin
      cy = carryIn[c] ^ subtract[c];
      for (int b = 0; b < CARRY_BITS; b++) begin
        bIn  = addB[c*CARRY_BITS+b] ^ subtract[c];
        prop = addA[c*CARRY_BITS+b] ^ bIn;
        // (R15) dedicated XOR completes the sum bit
        sum[c*CARRY_BITS+b] = prop ^ cy;
        // (R15) partial product AND, driven straight out on productBits
        productBits[c*CARRY_BITS+b] = ppA[c*CARRY_BITS+b] & ppB[c*CARRY_BITS+b];
        // (R14) carry select mux, chain runs upward
        cy = prop ? cy : addA[c*CARRY_BITS+b];
        topCarry[c*CARRY_BITS+b] = cy;
      end
      carryOut[c] = cy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sum-of-products chain

  // (R16) OR of previous row OR and own slice top carry
  always_comb begin
    for (int s = 0; s < SLICES; s++) begin
      sopOut[s] = sopIn[s] | topCarry[(s/2)*CARRY_BITS + (s%2)*2 + 1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus drivers built as AND-OR

  logic [BUS_LINES-1:0] busDrive;

  // (R17) (R18) (R21) driver d reaches line d or d+2
  always_comb begin
    busDrive = '0;
    for (int d = 0; d < BUS_DRIVERS; d++) begin
      busDrive[d + 2*busDrvLineSel[d]] = busDrvData[d] & busDrvEnable[d];
    end
    busLineOut = busLineIn | busDrive;
  end

  ////////////////////////////////////////////////////////////////////////////
  // slice flip-flop on the shift tap, for a clocked read

  typedef struct packed {
    logic tap;
  } clb_ff_s;

  clb_ff_s ff_reg;
  clb_ff_s ff_next;

  // (R10) useful only with a constant tap address
  always_comb begin
    ff_next     = ff_reg;
    ff_next.tap = shiftChainOut;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff_reg.tap <= RESET_FLAG;
    end else begin
      ff_reg <= ff_next;
    end
  end

  assign shiftTapReg = ff_reg.tap;

endmodule // clb_cluster

// file: bench/clb_cluster_properties.sv
// checker on the cluster ports, attached by bind from the bench
// assumes one clock domain and an async active-low reset
`timescale 1ns/1ps
module clb_cluster_properties
  import clb_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire clb_mode_e  mode,
  input wire logic [3:0] addr,
  input wire logic [3:0] readOnlyAddr,
  input wire logic [3:0] writeData,
  input wire logic       writeEn,
  input wire logic       shiftEn,
  input wire logic       shiftIn,
  input wire logic [6:0] chainAddr,
  input wire logic [7:0] addA,
  input wire logic [7:0] addB,
  input wire logic [1:0] carryIn,
  input wire logic [1:0] subtract,
  input wire logic [1:0] busDrvData,
  input wire logic [1:0] busDrvEnable,
  input wire logic [1:0] busDrvLineSel,
  input wire logic [7:0] lutRead,
  input wire logic [3:0] dualPortRead,
  input wire logic       shiftChainOut,
  input wire logic [7:0] sum,
  input wire logic [1:0] carryOut,
  input wire logic [3:0] busLineOut,
  input wire logic       shiftTapReg
);
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // contents and reads, tied to the request one edge earlier
  chk_tap_follow: assert property (rst_b |=> shiftTapReg == $past(shiftChainOut))
    else $error("tap flop does not trail the chain read");
  chk_rom_hold: assert property (mode == CLB_MODE_ROM ##1 mode == CLB_MODE_ROM && $stable(addr) |-> $stable(lutRead))
    else $error("rom contents moved");
  chk_shift_idle: assert property (mode == CLB_MODE_SHIFT && !shiftEn ##1 mode == CLB_MODE_SHIFT
    && $stable(chainAddr) |-> $stable(shiftChainOut))
    else $error("chain moved without a shift");
  chk_shift_entry: assert property (mode == CLB_MODE_SHIFT && shiftEn ##1 mode == CLB_MODE_SHIFT
    && chainAddr == 7'h00 |-> shiftChainOut == $past(shiftIn))
    else $error("serial input not in stage zero");
  chk_stage_step: assert property (mode == CLB_MODE_SHIFT && shiftEn ##1 mode == CLB_MODE_SHIFT && $past(chainAddr) != 7'h7F
    && chainAddr == $past(chainAddr) + 7'h01 |-> shiftChainOut == $past(shiftChainOut))
    else $error("stage did not move up by one");
  chk_ram_write: assert property (mode == CLB_MODE_SPRAM && writeEn ##1 mode == CLB_MODE_SPRAM && $stable(addr)
    |-> lutRead == {2{$past(writeData)}})
    else $error("single-port write not read back");
  chk_dual_write: assert property (mode == CLB_MODE_DPRAM && writeEn ##1 mode == CLB_MODE_DPRAM
    && readOnlyAddr == $past(addr) |-> dualPortRead == $past(writeData))
    else $error("second port misses the write");
  // arithmetic and bus are combinational relations
  chk_carry_sum: assert property ({carryOut[0], sum[3:0]} == {1'b0, addA[3:0]}
    + {1'b0, addB[3:0] ^ {4{subtract[0]}}} + {4'h0, carryIn[0] ^ subtract[0]})
    else $error("carry chain sum wrong");
  chk_bus_drive: assert property (busDrvEnable[1] && busDrvData[1] |-> busLineOut[{busDrvLineSel[1], 1'b1}])
    else $error("enabled driver missing on its line");
endmodule // clb_cluster_properties

// file: bench/clb_fabric_user.sv
// fabric logic that works the cluster's bus drivers and far lines
// assumes the same clock as the cluster; drives at the rising edge
`timescale 1ns/1ps
module clb_fabric_user (
  input  wire logic busRun,
  input  wire logic clk,
  output logic [1:0] busDrvData    = 2'h0,
  output logic [1:0] busDrvEnable  = 2'h0,
  output logic [1:0] busDrvLineSel = 2'h0,
  output logic [3:0] busLineIn     = 4'h0
);
  logic [9:0] pick;
  logic [3:0] claimed;
  ////////////////////////////////////////////////////////////
  // one driver per line: far traffic keeps off lines we claim
  always @(posedge clk) begin
    if (busRun) begin
      pick = 10'($urandom);
      claimed = 4'h0;
      for (int d = 0; d < 2; d++) if (pick[2 + d]) claimed[d + 2 * pick[4 + d]] = 1'b1;
      busDrvData <= pick[1:0];
      busDrvEnable <= pick[3:2];
      busDrvLineSel <= pick[5:4];
      busLineIn <= pick[9:6] & ~claimed;
    end
  end
endmodule // clb_fabric_user

// file: bench/clb_cluster_bench.sv
// self-checking bench for the logic cluster with its fabric partner
// assumes package, checker and partner are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module clb_cluster_bench;
  import clb_pkg::*;
  localparam logic [127:0] ROM_IMG = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  localparam clb_mode_e ORDER [6] = '{CLB_MODE_ROM, CLB_MODE_SPRAM, CLB_MODE_DPRAM,
                                      CLB_MODE_SHIFT, CLB_MODE_ROM, CLB_MODE_ROM};
  logic         clk = 1'b0, rst_b = 1'b0, writeEn = 1'b0, shiftEn = 1'b0, shiftIn = 1'b0;
  logic         upperWideIn = 1'b0, busRun = 1'b0;
  clb_mode_e    mode = CLB_MODE_ROM;
  logic [3:0]   addr = 4'h0, readOnlyAddr = 4'h0, wideSel = 4'h0, writeData = 4'h0, sopIn = 4'h0;
  logic [6:0]   chainAddr = 7'h00;
  logic [7:0]   addA = 8'h00, addB = 8'h00, ppA = 8'h00, ppB = 8'h00, lutRead, sum, productBits;
  logic [1:0]   carryIn = 2'h0, subtract = 2'h0, busDrvData, busDrvEnable, busDrvLineSel, carryOut;
  logic [3:0]   busLineIn, dualPortRead, sopOut, busLineOut;
  logic         wideMuxOut, wideMuxEightOut, shiftChainOut, shiftCascadeOut, shiftTapReg;
  logic [127:0] mem = ROM_IMG;
  logic         tapExp = 1'b0, sevenExp = 1'b0;
  int           bad_count = 0, samples_checked = 0, cycles = 0, n;

  clb_cluster #(
    .ROM_INIT (ROM_IMG)
  ) dut (
    .clk             (clk),
    .rst_b           (rst_b),
    .mode            (mode),
    .addr            (addr),
    .readOnlyAddr    (readOnlyAddr),
    .wideSel         (wideSel),
    .writeData       (writeData),
    .writeEn         (writeEn),
    .shiftEn         (shiftEn),
    .shiftIn         (shiftIn),
    .chainAddr       (chainAddr),
    .addA            (addA),
    .addB            (addB),
    .carryIn         (carryIn),
    .subtract        (subtract),
    .ppA             (ppA),
    .ppB             (ppB),
    .sopIn           (sopIn),
    .upperWideIn     (upperWideIn),
    .busDrvData      (busDrvData),
    .busDrvEnable    (busDrvEnable),
    .busDrvLineSel   (busDrvLineSel),
    .busLineIn       (busLineIn),
    .lutRead         (lutRead),
    .dualPortRead    (dualPortRead),
    .wideMuxOut      (wideMuxOut),
    .wideMuxEightOut (wideMuxEightOut),
    .shiftChainOut   (shiftChainOut),
    .shiftCascadeOut (shiftCascadeOut),
    .sum             (sum),
    .productBits     (productBits),
    .carryOut        (carryOut),
    .sopOut          (sopOut),
    .busLineOut      (busLineOut),
    .shiftTapReg     (shiftTapReg)
  );
  clb_fabric_user partner (
    .busRun        (busRun),
    .clk           (clk),
    .busDrvData    (busDrvData),
    .busDrvEnable  (busDrvEnable),
    .busDrvLineSel (busDrvLineSel),
    .busLineIn     (busLineIn)
  );
  ////////////////////////////////////////////////////////////
  // clock and a cycle ceiling well above the ~360 cycles needed
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [4:0] addExp(input logic [3:0] a, b, input logic ci, s);
    return {1'b0, a} + {1'b0, b ^ {4{s}}} + {4'h0, ci ^ s};
  endfunction

  function automatic logic [3:0] busExp(input logic [3:0] li, input logic [1:0] d, e, s);
    busExp = li;
    for (int k = 0; k < 2; k++) if (d[k] && e[k]) busExp[k + 2 * s[k]] = 1'b1;
  endfunction

  // slice s ORs its row input with the carry out of its own two bits
  function automatic logic [3:0] sopExp(input logic [7:0] a, b, input logic [1:0] ci, s, input logic [3:0] prev);
    logic [2:0] low;
    logic [4:0] full;
    for (int c = 0; c < 2; c++) begin
      low = {1'b0, a[4 * c +: 2]} + {1'b0, b[4 * c +: 2] ^ {2{s[c]}}} + {2'h0, ci[c] ^ s[c]};
      full = addExp(a[4 * c +: 4], b[4 * c +: 4], ci[c], s[c]);
      sopExp[2 * c] = prev[2 * c] | low[2];
      sopExp[2 * c + 1] = prev[2 * c + 1] | full[4];
    end
  endfunction
  ////////////////////////////////////////////////////////////
  // one cycle: update the model, drive new inputs, check mid-cycle
  task automatic step(input int t);
    @(posedge clk);
    tapExp = mem[chainAddr];  // chain read the tap flop took at this edge
    for (int i = 0; i < 8; i++) begin
      if (writeEn && mode == CLB_MODE_SPRAM) mem[i * 16 + addr] = writeData[i % 4];
      if (writeEn && mode == CLB_MODE_DPRAM) mem[i * 16 + addr] = writeData[i / 2];
    end
    if (shiftEn && mode == CLB_MODE_SHIFT) mem = {mem[126:0], shiftIn};
    if (n == 0) mode <= ORDER[t];
    busRun <= (t == 5);
    rst_b <= !(t == 4 && n == 1);  // mid-run reset must not touch contents
    {writeEn, writeData, shiftEn, shiftIn} <= 7'($urandom);
    addr <= n[0] ? addr : 4'($urandom);
    readOnlyAddr <= n[0] ? addr : 4'($urandom);
    // tap address held on some cycles so the tap flop reads a constant stage
    chainAddr <= (n % 5 == 0) ? 7'h00 : (n[1:0] == 2'b11) ? chainAddr : n[0] ? chainAddr + 7'h01 : 7'($urandom);
    // first two arithmetic cycles: full carry out, then a borrow
    {addA, addB, carryIn, subtract} <= (t == 4 && n < 2) ? (n ? 20'h00113 : 20'hFF11C) : 20'($urandom);
    {ppA, ppB, sopIn, wideSel, upperWideIn} <= 25'($urandom);
    @(negedge clk);
    sevenExp = mem[wideSel[2:0] * 16 + addr];
    case (t)
      0, 1, 4: begin
        for (int i = 0; i < 8; i++) `CHK(lutRead[i], mem[i * 16 + addr])
        `CHK({wideMuxOut, wideMuxEightOut}, {sevenExp, wideSel[3] ? upperWideIn : sevenExp})
      end
      2: for (int p = 0; p < 4; p++) `CHK({lutRead[2 * p], dualPortRead[p]}, {mem[32 * p + addr], mem[32 * p + 16 + readOnlyAddr]})
      3: begin
        `CHK({shiftChainOut, shiftCascadeOut, wideMuxOut}, {mem[chainAddr], mem[127], mem[chainAddr]})
        if (n > 0) `CHK(shiftTapReg, tapExp)
      end
      5: `CHK(busLineOut, busExp(busLineIn, busDrvData, busDrvEnable, busDrvLineSel))
      default: ;
    endcase
    if (t == 4) begin
      for (int c = 0; c < 2; c++) `CHK({carryOut[c], sum[4 * c +: 4]}, addExp(addA[4 * c +: 4], addB[4 * c +: 4], carryIn[c], subtract[c]))
      `CHK(productBits, ppA & ppB)
      `CHK(sopOut, sopExp(addA, addB, carryIn, subtract, sopIn))
      // tap flop must be cleared while the mid-run reset is low
      if (n == 1) `CHK(shiftTapReg, 1'b0)
    end
  endtask

  // rom, single port, dual port, shift chain, arithmetic, bus
  initial begin
    n = $urandom(90531);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int t = 0; t < 6; t++) begin
      for (n = 0; n < (t == 3 ? 150 : 40); n++) step(t);
      $display("test %0d done: checks %0d, mismatches %0d", t, samples_checked, bad_count);
    end
    close_out();
  end
endmodule // clb_cluster_bench

bind clb_cluster clb_cluster_properties chk (
  .clk           (clk),
  .rst_b         (rst_b),
  .mode          (mode),
  .addr          (addr),
  .readOnlyAddr  (readOnlyAddr),
  .writeData     (writeData),
  .writeEn       (writeEn),
  .shiftEn       (shiftEn),
  .shiftIn       (shiftIn),
  .chainAddr     (chainAddr),
  .addA          (addA),
  .addB          (addB),
  .carryIn       (carryIn),
  .subtract      (subtract),
  .busDrvData    (busDrvData),
  .busDrvEnable  (busDrvEnable),
  .busDrvLineSel (busDrvLineSel),
  .lutRead       (lutRead),
  .dualPortRead  (dualPortRead),
  .shiftChainOut (shiftChainOut),
  .sum           (sum),
  .carryOut      (carryOut),
  .busLineOut    (busLineOut),
  .shiftTapReg   (shiftTapReg)
);
